// ==== design/pcvt_ctrl.sv ====
// ****************************************************************
// Functional notes
// ****************************************************************
// ****************************************************************
// Design notes
// ****************************************************************
// All spacing holds count system clocks, each worth four DRAM clocks.
// DRAM-clock figures are rounded up, so every spacing errs long.
// Latency inputs already carry additive latency; the user sets them.
// Requests are refused, never dropped: the user holds them until ack.
// A read wins over a write when both are requested together.
// Same-rank write to read is judged against the last written rank,
// so an interleaved read to another rank cannot hide a pending turn.
// Other-rank write to write is judged against the last written rank too.
// The tracking window runs only after calibration has been seen.
// From mid-window a missing channel read is forced, then a gap.
// Forced reads reuse the last rank, which saves a rank turn.
// The update pulse needs returned data on both channels.
// A window with no returned data yet gets its pulse once data comes.
// Every command is placed in slot 0, the simplest even slot.
// Holds saturate at zero so an idle bus never wraps a counter.
// Known limit: a long write stream delays reads until mid-window.
// Forced actions block user traffic only while they are pending.
// Configuration inputs must stay static while traffic runs.
`timescale 1ns/1ps
`default_nettype none
module pcvt_ctrl (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic calibration_complete,        // From PHY
  input wire logic [1:0] read_data_valid,       // Per channel, from PHY
  input wire logic [1:0] per_read_done,         // Per channel, from PHY
  input wire logic user_rd_req,                 // User read request
  input wire logic user_wr_req,                 // User write request
  input wire logic [pcvt_pkg::RANK_W-1:0] user_rank, // Target rank
  input wire logic user_ch,                     // Target channel
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_rl, // Read latency incl. AL, DRAM clocks
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_wl, // Write latency incl. AL
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_bl, // Burst length
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_twtr, // Same-rank write to read
  output logic user_rd_ack,                     // Read taken this cycle
  output logic user_wr_ack,                     // Write taken this cycle
  output logic read_cas_strobe,                 // To PHY
  output logic write_cas_strobe,                // To PHY
  output logic [1:0] cas_slot,                  // Command slot of the CAS
  output logic [pcvt_pkg::RANK_W-1:0] cas_rank, // Rank of the CAS
  output logic [1:0] cas_ch_sel,                // Channel select, one-hot
  output logic training_update_pulse            // To PHY, all channels
);
  // ****************************************************************
  // Types and helpers
  // ****************************************************************
  typedef enum logic [3:0] {
    PCVT_IDLE = 4'h1,   // Waiting for calibration
    PCVT_RUN = 4'h2,    // Normal traffic
    PCVT_TRK_RD = 4'h4, // Forced tracking read
    PCVT_GAP = 4'h8     // Forced read-free gap
  } pcvt_st_t;

  // DRAM clocks to system clocks, rounded up
  function automatic logic [pcvt_pkg::SP_W-1:0] dck2sys(input logic [pcvt_pkg::SP_W-1:0] d);
    logic [pcvt_pkg::SP_W:0] s;
    s = {1'b0, d} + (pcvt_pkg::SP_W+1)'(pcvt_pkg::DRAM_PER_SYS - 1);
    dck2sys = s[pcvt_pkg::SP_W:1] >> 1;
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  pcvt_st_t st_r, st_nxt;                              // Tracking state
  logic [pcvt_pkg::CTR_W-1:0] win_r, win_nxt;          // Window counter
  logic [pcvt_pkg::SP_W-1:0] rd_hold_r, rd_hold_nxt;   // Cycles until a read may go
  logic [pcvt_pkg::SP_W-1:0] wr_hold_r, wr_hold_nxt;   // Cycles until a write may go
  logic [pcvt_pkg::SP_W-1:0] wr_xr_r, wr_xr_nxt;       // Other-rank write hold
  logic [pcvt_pkg::SP_W-1:0] rd_xr_r, rd_xr_nxt;       // Other-rank read hold
  logic [pcvt_pkg::SP_W-1:0] wtr_sr_r, wtr_sr_nxt;     // Same-rank write to read hold
  logic [pcvt_pkg::RANK_W-1:0] last_rank_r, last_rank_nxt; // Rank of last CAS
  logic [pcvt_pkg::RANK_W-1:0] last_wr_rank_r, last_wr_rank_nxt; // Rank of last write
  logic [1:0] rd_seen_r, rd_seen_nxt;                  // Read issued per channel
  logic [1:0] val_seen_r, val_seen_nxt;                // Valid or done per channel
  logic pulsed_r, pulsed_nxt;                          // Pulse given this window
  logic [1:0] gap_r, gap_nxt;                          // Current read-free run
  logic gap_ok_r, gap_ok_nxt;                          // Gap achieved this window
  logic trk_ch_r, trk_ch_nxt;                          // Channel of forced read
  logic [1:0] sync_cal_r;                              // Calibration synchroniser
  logic rd_go, wr_go, trk_go, rd_ok, wr_ok, same;
  logic rcas_nxt, wcas_nxt, pulse_nxt;
  logic [pcvt_pkg::RANK_W-1:0] rank_nxt, rank_sel;
  logic [1:0] ch_nxt;
  logic ch_sel;
  logic win_end;
  logic [pcvt_pkg::SP_W-1:0] rd2wr;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Spacing, tracking and issue decisions
  always_comb begin
    st_nxt = st_r;
    win_nxt = win_r;
    rd_seen_nxt = rd_seen_r;
    val_seen_nxt = val_seen_r | read_data_valid | per_read_done;
    pulsed_nxt = pulsed_r;
    gap_ok_nxt = gap_ok_r;
    trk_ch_nxt = trk_ch_r;
    last_rank_nxt = last_rank_r;
    last_wr_rank_nxt = last_wr_rank_r;
    pulse_nxt = 1'b0;
    win_end = (win_r == pcvt_pkg::CTR_W'(pcvt_pkg::WINDOW_CYC - 1));
    // Latency inputs include additive latency, so spacing follows it
    // Read to write gap, margin for board skew
    rd2wr = dck2sys(cfg_rl + (cfg_bl >> 1) + pcvt_pkg::SP_W'(pcvt_pkg::RD_WR_EXTRA_DCK)
      - cfg_wl);
    // Forced reads target the remembered rank and channel
    rank_sel = user_rank;
    ch_sel = user_ch;
    if (st_r == PCVT_TRK_RD) begin
      rank_sel = last_rank_r;
      ch_sel = trk_ch_r;
    end
    same = (rank_sel == last_rank_r);
    // Reads wait on every applicable spacing
    rd_ok = (rd_hold_r == '0) && (same || (rd_xr_r == '0))
      && ((rank_sel != last_wr_rank_r) || (wtr_sr_r == '0));
    wr_ok = (wr_hold_r == '0) && ((rank_sel == last_wr_rank_r) || (wr_xr_r == '0));
    // Issue decisions for forced and user commands
    trk_go = (st_r == PCVT_TRK_RD) && rd_ok;
    rd_go = (st_r == PCVT_RUN) && user_rd_req && rd_ok;
    wr_go = (st_r == PCVT_RUN) && user_wr_req && !user_rd_req && wr_ok;
    if (st_r == PCVT_GAP) begin
      rd_go = 1'b0;
    end
    // Strobes and select lines for the next cycle
    rcas_nxt = rd_go || trk_go;
    wcas_nxt = wr_go;
    rank_nxt = rank_sel;
    ch_nxt = ch_sel ? 2'h2 : 2'h1;
    // Holds count down, then reload on a CAS
    rd_hold_nxt = (rd_hold_r != '0) ? rd_hold_r - 1'b1 : '0;
    wr_hold_nxt = (wr_hold_r != '0) ? wr_hold_r - 1'b1 : '0;
    wr_xr_nxt = (wr_xr_r != '0) ? wr_xr_r - 1'b1 : '0;
    rd_xr_nxt = (rd_xr_r != '0) ? rd_xr_r - 1'b1 : '0;
    wtr_sr_nxt = (wtr_sr_r != '0) ? wtr_sr_r - 1'b1 : '0;
    // A read reloads the read-to-write and other-rank read holds
    if (rcas_nxt) begin
      wr_hold_nxt = rd2wr;
      rd_xr_nxt = dck2sys(pcvt_pkg::SP_W'(pcvt_pkg::XRANK_RD_DCK));
      last_rank_nxt = rank_sel;
      rd_seen_nxt[ch_sel] = 1'b1;
    end
    // A write reloads the write-related holds
    if (wcas_nxt) begin
      last_wr_rank_nxt = rank_sel;
      wtr_sr_nxt = dck2sys(cfg_wl + (cfg_bl >> 1) + cfg_twtr);
      rd_xr_nxt = dck2sys(pcvt_pkg::SP_W'(pcvt_pkg::XRANK_WR_RD_DCK));
      wr_xr_nxt = dck2sys(pcvt_pkg::SP_W'(pcvt_pkg::XRANK_WR_WR_DCK));
      rd_hold_nxt = '0;
      last_rank_nxt = rank_sel;
    end
    // Read-free run tracking
    gap_nxt = rcas_nxt ? 2'h0 : ((gap_r == 2'h3) ? gap_r : gap_r + 2'h1);
    if (gap_nxt == 2'(pcvt_pkg::GAP_CYC)) begin
      gap_ok_nxt = 1'b1;
    end
    // One pulse per window once data came back on both channels
    if (!pulsed_r && (val_seen_nxt == 2'h3) && st_r != PCVT_IDLE) begin
      pulse_nxt = 1'b1;
      pulsed_nxt = 1'b1;
    end
    // Window runs once normal traffic has started
    if (st_r != PCVT_IDLE) begin
      win_nxt = win_end ? '0 : win_r + 1'b1;
    end
    case (st_r)
      PCVT_IDLE: begin
        // Leave idle once synchronised calibration is seen
        if (sync_cal_r[1]) begin
          st_nxt = PCVT_RUN;
        end
      end
      PCVT_RUN: begin
        // Decide late in the window what is still needed
        if (win_r >= pcvt_pkg::CTR_W'(pcvt_pkg::WINDOW_CYC / 2)) begin
          if (rd_seen_r != 2'h3) begin
            st_nxt = PCVT_TRK_RD;
            trk_ch_nxt = rd_seen_r[0];
          end else if (!gap_ok_r) begin
            st_nxt = PCVT_GAP;
          end
        end
      end
      PCVT_TRK_RD: begin
        // Stay until the forced read has gone out
        if (trk_go) begin
          st_nxt = PCVT_RUN;
        end
      end
      PCVT_GAP: begin
        // Stay until three read-free cycles are in
        if (gap_ok_nxt) begin
          st_nxt = PCVT_RUN;
        end
      end
      default: begin
        // Illegal code: return to idle
        st_nxt = PCVT_IDLE;
      end
    endcase
    // Window end clears the per-window records
    if (win_end) begin
      rd_seen_nxt = 2'h0;
      val_seen_nxt = 2'h0;
      pulsed_nxt = 1'b0;
      gap_ok_nxt = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Registered state, outputs and synchroniser
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      // Hold everything at its idle value
      st_r <= PCVT_IDLE;
      win_r <= '0;
      rd_hold_r <= '0;
      wr_hold_r <= '0;
      wr_xr_r <= '0;
      rd_xr_r <= '0;
      wtr_sr_r <= '0;
      last_rank_r <= '0;
      last_wr_rank_r <= '0;
      rd_seen_r <= '0;
      val_seen_r <= '0;
      pulsed_r <= 1'b0;
      gap_r <= '0;
      gap_ok_r <= 1'b0;
      trk_ch_r <= 1'b0;
      sync_cal_r <= '0;
      read_cas_strobe <= 1'b0;
      write_cas_strobe <= 1'b0;
      cas_rank <= '0;
      cas_ch_sel <= '0;
      training_update_pulse <= 1'b0;
    end else begin
      // Advance all state
      st_r <= st_nxt;
      win_r <= win_nxt;
      rd_hold_r <= rd_hold_nxt;
      wr_hold_r <= wr_hold_nxt;
      wr_xr_r <= wr_xr_nxt;
      rd_xr_r <= rd_xr_nxt;
      wtr_sr_r <= wtr_sr_nxt;
      last_rank_r <= last_rank_nxt;
      last_wr_rank_r <= last_wr_rank_nxt;
      rd_seen_r <= rd_seen_nxt;
      val_seen_r <= val_seen_nxt;
      pulsed_r <= pulsed_nxt;
      gap_r <= gap_nxt;
      gap_ok_r <= gap_ok_nxt;
      trk_ch_r <= trk_ch_nxt;
      // Two-flop synchroniser for calibration
      sync_cal_r <= {sync_cal_r[0], calibration_complete};
      read_cas_strobe <= rcas_nxt;
      write_cas_strobe <= wcas_nxt;
      cas_rank <= rank_nxt;
      // Channel select shows only while a CAS stands
      cas_ch_sel <= (rcas_nxt || wcas_nxt) ? ch_nxt : 2'h0;
      training_update_pulse <= pulse_nxt;
    end
  end

  // CAS always uses slot 0
  assign cas_slot = 2'h0;
  // Acks are combinational: a request is taken this cycle
  assign user_rd_ack = rd_go;
  assign user_wr_ack = wr_go;
endmodule
`default_nettype wire

// ==== design/pcvt_pkg.sv ====
package pcvt_pkg;
  // ****************************************************************
  // Timing constants
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;                       // System clock period
  localparam int WINDOW_NS = 1000;                         // Tracking window, 1 us
  localparam int WINDOW_CYC = WINDOW_NS / CLK_PERIOD_NS;   // Cycles per window
  localparam int CTR_W = 16;                               // Window counter width
  localparam int DRAM_PER_SYS = 4;                         // DRAM clocks per system clock
  localparam int GAP_CYC = 3;                              // Read-free gap length
  localparam int XRANK_RD_DCK = 6;                         // Read to read, other rank
  localparam int XRANK_WR_RD_DCK = 6;                      // Write to read, other rank
  localparam int XRANK_WR_WR_DCK = 8;                      // Write to write, other rank
  localparam int RD_WR_EXTRA_DCK = 4;                      // Skew margin, read to write
  localparam int SP_W = 8;                                 // Spacing counter width
  localparam int RANK_W = 2;                               // Rank field width
endpackage

// ==== sim/pcvt_ctrl_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// CAS spacing and tracking upkeep checker
// ****************************************************************
module pcvt_ctrl_chk (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic calibration_complete,
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_rl,
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_wl,
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_bl,
  input wire logic [pcvt_pkg::SP_W-1:0] cfg_twtr,
  input wire logic read_cas_strobe,
  input wire logic write_cas_strobe,
  input wire logic [1:0] cas_slot,
  input wire logic [pcvt_pkg::RANK_W-1:0] cas_rank,
  input wire logic [1:0] cas_ch_sel,
  input wire logic training_update_pulse
);
  logic [15:0] srd_r, swr_r, rd0_r, rd1_r, upd_r, gap_r, run_r; // Cycle ages
  logic [pcvt_pkg::RANK_W-1:0] wrk_r; // Rank of the last write
  int rdwr, wrrd; // Required spacings in system cycles
  assign rdwr = (int'(cfg_rl) + int'(cfg_bl) / 2 + 4 - int'(cfg_wl) + 3) / 4;
  assign wrrd = (int'(cfg_wl) + int'(cfg_bl) / 2 + int'(cfg_twtr) + 3) / 4;
  // Ages restart with calibration, so upkeep is only judged after it
  always_ff @(posedge core_clk) begin
    if (!nrst || !calibration_complete) begin
      {srd_r, swr_r} <= {16'h8000, 16'h8000};
      {rd0_r, rd1_r, upd_r, gap_r, run_r} <= '0;
      wrk_r <= '0;
    end else begin
      srd_r <= read_cas_strobe ? 16'h0001 : srd_r + 16'h0001;
      swr_r <= write_cas_strobe ? 16'h0001 : swr_r + 16'h0001;
      wrk_r <= write_cas_strobe ? cas_rank : wrk_r;
      rd0_r <= (read_cas_strobe && cas_ch_sel[0]) ? 16'h0000 : rd0_r + 16'h0001;
      rd1_r <= (read_cas_strobe && cas_ch_sel[1]) ? 16'h0000 : rd1_r + 16'h0001;
      upd_r <= training_update_pulse ? 16'h0000 : upd_r + 16'h0001;
      run_r <= read_cas_strobe ? 16'h0000 : run_r + 16'h0001;
      gap_r <= (run_r >= 16'h0003) ? 16'h0000 : gap_r + 16'h0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rd_rd; read_cas_strobe |=> !(read_cas_strobe && cas_rank != $past(cas_rank)); endproperty
  a_rd_rd: assert property (p_rd_rd) else $error("read to other rank too soon");
  property p_wr_rd; write_cas_strobe |=> !(read_cas_strobe && cas_rank != $past(cas_rank)); endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("write then read too soon");
  property p_wr_wr; write_cas_strobe |=> !(write_cas_strobe && cas_rank != $past(cas_rank)); endproperty
  a_wr_wr: assert property (p_wr_wr) else $error("write to other rank too soon");
  property p_rd_wr; write_cas_strobe |-> srd_r >= rdwr; endproperty
  a_rd_wr: assert property (p_rd_wr) else $error("read then write too soon");
  property p_wr_rd_same; read_cas_strobe && cas_rank == wrk_r |-> swr_r >= wrrd; endproperty
  a_wr_rd_same: assert property (p_wr_rd_same) else $error("same rank read too soon");
  property p_cas_form; read_cas_strobe || write_cas_strobe |-> cas_slot == 2'h0 &&
    !(read_cas_strobe && write_cas_strobe) && $onehot(cas_ch_sel); endproperty
  a_cas_form: assert property (p_cas_form) else $error("bad CAS form");
  property p_upd_one; training_update_pulse |=> !training_update_pulse; endproperty
  a_upd_one: assert property (p_upd_one) else $error("update pulse too long");
  property p_ages; rd0_r < 16'h00C8 && rd1_r < 16'h00C8 && upd_r < 16'h00C8 &&
    gap_r < 16'h00C8; endproperty
  a_ages: assert property (p_ages) else $error("tracking upkeep late");
endmodule
bind pcvt_ctrl pcvt_ctrl_chk i_chk (.core_clk, .nrst, .calibration_complete, .cfg_rl, .cfg_wl,
  .cfg_bl, .cfg_twtr, .read_cas_strobe, .write_cas_strobe, .cas_slot, .cas_rank, .cas_ch_sel,
  .training_update_pulse);
`default_nettype wire

// ==== sim/pcvt_ctrl_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("unexpected %s exp %0h got %0h", nm, ex, got); end end
module pcvt_ctrl_tb_top;
  // ****************************************************************
  // Stimulus, scoreboard and verdict
  // ****************************************************************
  logic core_clk = 1'b0, nrst = 1'b0, user_rd_req = 1'b0, user_wr_req = 1'b0, user_ch = 1'b0;
  logic [pcvt_pkg::RANK_W-1:0] user_rank = '0, cas_rank;
  logic [pcvt_pkg::SP_W-1:0] cfg_rl = 8'h0B, cfg_wl = 8'h09, cfg_bl = 8'h08, cfg_twtr = 8'h04;
  logic calibration_complete, user_rd_ack, user_wr_ack, read_cas_strobe, write_cas_strobe;
  logic training_update_pulse, ack_d = 1'b0;
  logic [1:0] read_data_valid, per_read_done, cas_slot, cas_ch_sel;
  logic [5:0] exp_q [$], e; // Expected {read, write, rank, channel} per taken request
  int n_errors = 0, n_tests = 0, seed = 69648, n_upd, cyc = 0, n_wdr, n_wr = 0;
  always #5 core_clk = ~core_clk;
  pcvt_ctrl i_dut (.core_clk, .nrst, .calibration_complete, .read_data_valid, .per_read_done,
    .user_rd_req, .user_wr_req, .user_rank, .user_ch, .cfg_rl, .cfg_wl, .cfg_bl, .cfg_twtr,
    .user_rd_ack, .user_wr_ack, .read_cas_strobe, .write_cas_strobe, .cas_slot, .cas_rank,
    .cas_ch_sel, .training_update_pulse);
  // Read latency of 11 DRAM clocks is 3 system cycles
  pcvt_phy_model #(.RD_LAT(3), .CAL_CYC(20)) i_phy (.core_clk, .nrst, .read_cas_strobe,
    .cas_ch_sel, .training_update_pulse, .calibration_complete, .read_data_valid,
    .per_read_done, .n_upd, .write_cas_strobe, .n_wdr);
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Present one request, hold it until taken, note the expected CAS
  task automatic issue(input logic rd, input logic [1:0] rank, input logic ch);
    int k = 0;
    user_rd_req <= rd;
    user_wr_req <= !rd;
    user_rank <= rank;
    user_ch <= ch;
    do @(posedge core_clk); while (++k < 400 && (user_rd_ack | user_wr_ack) !== 1'b1);
    if (k >= 400) begin
      n_errors++;
      report_and_stop();
    end
    exp_q.push_back({rd, !rd, rank, ch, !ch});
    n_wr += int'(!rd);
  endtask
  // Match each CAS to the oldest note; an untaken CAS must be a tracking read
  always @(posedge core_clk) begin
    ack_d <= nrst & (user_rd_ack | user_wr_ack);
    cyc <= cyc + int'(calibration_complete === 1'b1);
    if (ack_d === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 6'h00;
      `CHK("cas", e, {read_cas_strobe, write_cas_strobe, cas_rank, cas_ch_sel})
    end else if ((read_cas_strobe | write_cas_strobe) === 1'b1) begin
      `CHK("tracking read", 3'h7, {read_cas_strobe, !write_cas_strobe, cas_ch_sel != 2'h0})
    end
  end
  initial begin
    logic [3:0] pairs [12] = '{4'h8, 4'hA, 4'h2, 4'hC, 4'h4, 4'h0, 4'h8, 4'h0, 4'h8, 4'h6,
      4'h9, 4'h3};
    int k;
    repeat (2) @(posedge core_clk);
    `CHK("reset", 5'h00, {read_cas_strobe, write_cas_strobe, training_update_pulse, cas_ch_sel})
    nrst <= 1'b1;
    user_rd_req <= 1'b1;
    for (k = 0; k < 300 && calibration_complete !== 1'b1; k++) @(posedge core_clk);
    user_rd_req <= 1'b0;
    `CHK("calibration", 1'b1, calibration_complete)
    repeat (4) @(posedge core_clk);
    // Tight pairs: other-rank and same-rank turns in both directions
    foreach (pairs[i]) issue(pairs[i][3], pairs[i][2:1], pairs[i][0]);
    // Reads only, then writes only, then mixed random traffic
    for (k = 0; k < 600; k++)
      issue(k < 200 || (k >= 400 && ($random(seed) & 1) != 0), 2'($random(seed)), 1'($random(seed)));
    user_rd_req <= 1'b0;
    user_wr_req <= 1'b0;
    repeat (300) @(posedge core_clk);
    `CHK("open requests", 0, exp_q.size())
    `CHK("update pulses", 1'b1, n_upd >= cyc / 100 - 1)
    `CHK("write data requests", n_wr, n_wdr)
    report_and_stop();
  end
endmodule
`default_nettype wire

// ==== sim/pcvt_phy_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// PHY stand-in: calibration, read return, update count
// ****************************************************************
module pcvt_phy_model #(
  parameter int RD_LAT = 3, // System cycles from read CAS to data, AL included
  parameter int CAL_CYC = 20, // Cycles until calibration ends
  parameter int WR_LAT = 3 // System cycles from write CAS to data request, AL included
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic read_cas_strobe,
  input wire logic [1:0] cas_ch_sel,
  input wire logic training_update_pulse,
  input wire logic write_cas_strobe,
  output logic calibration_complete,
  output logic [1:0] read_data_valid,
  output logic [1:0] per_read_done,
  output int n_upd,
  output int n_wdr
);
  logic [1:0] pipe_r [RD_LAT]; // Read return pipe per channel
  logic wpipe_r [WR_LAT]; // Write data request pipe
  int cal_n; // Calibration timer
  // Never stalls the controller; data returns a fixed latency later
  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      pipe_r <= '{default: 2'h0};
      {cal_n, n_upd, per_read_done} <= '0;
      wpipe_r <= '{default: 1'b0};
      n_wdr <= 0;
    end else begin
      pipe_r[0] <= read_cas_strobe ? cas_ch_sel : 2'h0;
      for (int i = 1; i < RD_LAT; i++) pipe_r[i] <= pipe_r[i - 1];
      wpipe_r[0] <= write_cas_strobe;
      for (int i = 1; i < WR_LAT; i++) wpipe_r[i] <= wpipe_r[i - 1];
      n_wdr <= n_wdr + int'(wpipe_r[WR_LAT - 1]);
      per_read_done <= read_data_valid;
      cal_n <= (cal_n < CAL_CYC) ? cal_n + 1 : cal_n;
      n_upd <= n_upd + int'(training_update_pulse);
    end
  end
  assign calibration_complete = (cal_n >= CAL_CYC);
  assign read_data_valid = pipe_r[RD_LAT - 1];
endmodule
`default_nettype wire
